// File: verilog/fcm_config_manager.sv
// FPGA configuration manager: boot image select, reloads, PCIe hold-over.
// Assumes synchronous inputs on clk_in and a host that sets the image first.
`timescale 1ns/100ps
`default_nettype none
module fcm_config_manager (
    // Clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       srst_in,
    // Board straps and JTAG presence
    input  wire logic [fcm_pkg::IMG_W-1:0]  boot_switch_in,
    input  wire logic                       jtag_active_in,
    // Host configuration access and commands
    input  wire fcm_pkg::fcm_cfg_req_s      cfg_req_in,
    output var  fcm_pkg::fcm_cfg_rsp_s      cfg_rsp_out,
    input  wire fcm_pkg::fcm_cmd_s          cmd_in,
    input  wire logic                       flash_wr_req_in,
    // FPGA configuration port
    output logic                            fpga_prog_out,
    output logic                            fpga_cfg_valid_out,
    output logic [7:0]                      fpga_cfg_byte_out,
    input  wire logic                       fpga_done_in,
    output logic                            cfg_drive_n_out,
    // Flash read engine
    output logic                            flash_rd_start_out,
    output logic [fcm_pkg::IMG_W-1:0]       flash_image_out,
    output logic                            flash_wr_grant_out,
    input  wire logic                       flash_byte_valid_in,
    input  wire logic [7:0]                 flash_byte_in,
    input  wire logic                       flash_last_in,
    // Status
    output logic                            traffic_enable_out,
    output logic [2:0]                      state_out
);
    import fcm_pkg::*;

    fcm_state_e        state_reg, state_next;
    logic              boot_done_reg;
    logic [IMG_W-1:0]  image_reg;
    logic [31:0]       timer_reg;
    logic              prog_reg, cfg_valid_reg, rd_start_reg, traffic_reg;
    logic              drive_n_reg, wr_grant_reg;
    logic [7:0]        cfg_byte_reg;

    // ---------------------------------------------------------------
    // Preserved configuration space
    // ---------------------------------------------------------------
    // target present at once
    fcm_cfg_space u_cfg (
        .clk_in  (clk_in),
        .srst_in (srst_in),
        .req_in  (cfg_req_in),
        .rsp_out (cfg_rsp_out)
    );

    // Loading states
    function automatic logic is_loading(input fcm_state_e s);
        return s == FCM_LOAD_FLASH || s == FCM_LOAD_HOST || s == FCM_LOAD_JTAG;
    endfunction

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            FCM_BOOT_SEL: begin
                state_next = FCM_LOAD_FLASH;
            end
            FCM_LOAD_FLASH, FCM_LOAD_HOST, FCM_LOAD_JTAG: begin
                if (fpga_done_in && !prog_reg) begin
                    state_next = FCM_RUN;
                end else if (timer_reg >= LOAD_TIMEOUT_CYC) begin
                    state_next = FCM_FAULT;
                end
            end
            FCM_RUN, FCM_FAULT: begin
                if (jtag_active_in) begin
                    state_next = FCM_LOAD_JTAG;
                end else if (cmd_in.reload) begin
                    state_next = FCM_LOAD_FLASH;
                end else if (cmd_in.stream_start) begin
                    state_next = FCM_LOAD_HOST;
                end
            end
            default: state_next = FCM_FAULT;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg <= FCM_BOOT_SEL;
        end else begin
            state_reg <= state_next;
        end
    end

    // Image index: switch at boot, host selection afterwards
    // switch picks boot image
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            image_reg     <= '0;
            boot_done_reg <= 1'b0;
        end else if (!boot_done_reg) begin
            image_reg     <= boot_switch_in;
            boot_done_reg <= 1'b1;
        end else if (!is_loading(state_reg)) begin
            image_reg <= cmd_in.image;
        end
    end

    // Load timer
    always_ff @(posedge clk_in) begin
        if (srst_in || !is_loading(state_reg)) begin
            timer_reg <= 32'h0000_0000;
        end else if (timer_reg < LOAD_TIMEOUT_CYC) begin
            timer_reg <= timer_reg + 32'h0000_0001;
        end
    end

    // Program pulse on entry to a flash or host load; flash start on entry to a flash load
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            prog_reg     <= 1'b0;
            rd_start_reg <= 1'b0;
        end else begin
            prog_reg     <= (state_next != state_reg) && is_loading(state_next)
                            && state_next != FCM_LOAD_JTAG;
            rd_start_reg <= (state_next == FCM_LOAD_FLASH) && (state_reg != FCM_LOAD_FLASH);
        end
    end

    // Byte path into the FPGA; host bytes never reach flash
    // stream direct to FPGA
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cfg_valid_reg <= 1'b0;
            cfg_byte_reg  <= 8'h00;
        end else if (state_reg == FCM_LOAD_HOST) begin
            cfg_valid_reg <= cmd_in.stream_valid;
            cfg_byte_reg  <= cmd_in.stream_byte;
        end else if (state_reg == FCM_LOAD_FLASH) begin
            cfg_valid_reg <= flash_byte_valid_in;
            cfg_byte_reg  <= flash_byte_in;
        end else begin
            cfg_valid_reg <= 1'b0;
            cfg_byte_reg  <= 8'h00;
        end
    end

    // Release config pins to JTAG; grant flash writes when idle
    // pins released for JTAG
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            drive_n_reg  <= 1'b1;
            wr_grant_reg <= 1'b0;
        end else begin
            drive_n_reg  <= !(state_next == FCM_LOAD_FLASH || state_next == FCM_LOAD_HOST);
            wr_grant_reg <= flash_wr_req_in && !is_loading(state_reg);
        end
    end

    // Traffic passes to the FPGA only after done
    // gate traffic until done
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            traffic_reg <= 1'b0;
        end else begin
            traffic_reg <= (state_next == FCM_RUN);
        end
    end

    assign fpga_prog_out      = prog_reg;
    assign fpga_cfg_valid_out = cfg_valid_reg;
    assign fpga_cfg_byte_out  = cfg_byte_reg;
    assign cfg_drive_n_out    = drive_n_reg;
    assign flash_rd_start_out = rd_start_reg;
    assign flash_image_out    = image_reg;
    assign flash_wr_grant_out = wr_grant_reg;
    assign traffic_enable_out = traffic_reg;
    assign state_out          = state_reg;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence s_reload_cmd;
        (state_reg == FCM_RUN) && !jtag_active_in && cmd_in.reload;
    endsequence

    AST_NO_TRAFFIC_LOADING: assert property (@(posedge clk_in) disable iff (srst_in)
        is_loading(state_reg) |-> !traffic_enable_out)
        else $error("traffic open during load");
    AST_RELOAD_FLASH: assert property (@(posedge clk_in) disable iff (srst_in)
        s_reload_cmd |=> state_reg == FCM_LOAD_FLASH && flash_rd_start_out
        && fpga_prog_out)
        else $error("reload did not start flash load");
    AST_JTAG_HANDS_OFF: assert property (@(posedge clk_in) disable iff (srst_in)
        state_reg == FCM_LOAD_JTAG |-> cfg_drive_n_out && !fpga_cfg_valid_out)
        else $error("manager drives during JTAG load");
    AST_BOOT_SWITCH: assert property (@(posedge clk_in)
        $fell(srst_in) |=> flash_image_out == $past(boot_switch_in))
        else $error("boot image not from switch");
    AST_FIRST_LOAD: assert property (@(posedge clk_in) disable iff (srst_in)
        $past(srst_in) |-> ##1 state_reg == FCM_LOAD_FLASH)
        else $error("no boot load");
    AST_STREAM_PASS: assert property (@(posedge clk_in) disable iff (srst_in)
        state_reg == FCM_LOAD_HOST && cmd_in.stream_valid |=>
        fpga_cfg_valid_out && fpga_cfg_byte_out == $past(cmd_in.stream_byte))
        else $error("stream byte lost");
    AST_NO_GRANT_LOADING: assert property (@(posedge clk_in) disable iff (srst_in)
        is_loading(state_reg) |=> !flash_wr_grant_out)
        else $error("flash write during load");
    AST_DONE_RUN: assert property (@(posedge clk_in) disable iff (srst_in)
        is_loading(state_reg) && fpga_done_in && !prog_reg |=>
        state_reg == FCM_RUN ##0 traffic_enable_out)
        else $error("done not taken");
    AST_IMAGE_RANGE: assert property (@(posedge clk_in) disable iff (srst_in)
        32'(flash_image_out) < N_IMAGES)
        else $error("image out of range");
endmodule // fcm_config_manager
`default_nettype wire

// File: pkg/fcm_pkg.sv
// Package for the FPGA configuration manager: states, limits, carriers.
// Assumes one 10 MHz clock and a synchronous active-high reset.
`default_nettype none
package fcm_pkg;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned DISCOVER_MS      = 100;
    localparam int unsigned DISCOVER_CYC     = (CLK_HZ / 1000) * DISCOVER_MS;
    localparam int unsigned LOAD_TIMEOUT_CYC = 2 * DISCOVER_CYC;
    // ---------------------------------------------------------------
    // Images and identity
    // ---------------------------------------------------------------
    localparam int unsigned N_IMAGES   = 4;
    localparam int unsigned IMG_W      = 2;
    localparam logic [15:0] VENDOR_ID  = 16'h1234; // Arbitrary value
    localparam logic [15:0] DEVICE_ID  = 16'h5678; // Arbitrary value
    localparam logic [7:0]  CFG_CMD_W  = 8'h01;
    localparam logic [7:0]  CFG_CMD_R  = 8'h00;
    localparam logic [7:0]  CFG_ID_DW  = 8'h00;
    localparam int unsigned CFG_DW     = 16;
    localparam int unsigned CFG_AW     = 4;

    typedef enum logic [2:0] {
        FCM_BOOT_SEL   = 3'b000,
        FCM_LOAD_FLASH = 3'b001,
        FCM_LOAD_HOST  = 3'b010,
        FCM_LOAD_JTAG  = 3'b011,
        FCM_RUN        = 3'b100,
        FCM_FAULT      = 3'b101
    } fcm_state_e;

    // Host configuration access request
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [CFG_AW-1:0] addr;
        logic [31:0]       data;
    } fcm_cfg_req_s;

    // Host configuration answer
    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } fcm_cfg_rsp_s;

    // Commands from host software
    typedef struct packed {
        logic             reload;
        logic [IMG_W-1:0] image;
        logic             stream_start;
        logic             stream_valid;
        logic [7:0]       stream_byte;
        logic             stream_last;
    } fcm_cmd_s;
endpackage : fcm_pkg
`default_nettype wire

// File: verilog/fcm_cfg_space.sv
// Preserved PCIe configuration space, answered by the manager itself.
// Assumes one access request at a time from the endpoint core.
`timescale 1ns/100ps
`default_nettype none
module fcm_cfg_space (
    // Clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  srst_in,
    // Access
    input  wire fcm_pkg::fcm_cfg_req_s req_in,
    output var  fcm_pkg::fcm_cfg_rsp_s rsp_out
);
    import fcm_pkg::*;

    logic [31:0] space_reg [CFG_DW];
    fcm_cfg_rsp_s rsp_reg;

    // ---------------------------------------------------------------
    // Storage: word 0 is the read-only identity, never overwritten
    // ---------------------------------------------------------------
    // space kept intact
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            for (int i = 0; i < CFG_DW; i++) begin
                space_reg[i] <= 32'h0000_0000;
            end
        end else if (req_in.valid && req_in.write
                     && req_in.addr != CFG_AW'(CFG_ID_DW)) begin
            space_reg[req_in.addr] <= req_in.data;
        end
    end

    // Answer one cycle after the request
    // fixed device identity
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.valid <= req_in.valid;
            rsp_reg.data  <= (req_in.addr == CFG_AW'(CFG_ID_DW)) ?
                             {DEVICE_ID, VENDOR_ID} : space_reg[req_in.addr];
        end
    end

    assign rsp_out = rsp_reg;

    AST_ID_FIXED: assert property (@(posedge clk_in) disable iff (srst_in)
        req_in.valid && req_in.addr == CFG_AW'(CFG_ID_DW) |=>
        rsp_out.valid && rsp_out.data == {DEVICE_ID, VENDOR_ID})
        else $error("identity word changed");
endmodule // fcm_cfg_space
`default_nettype wire

// File: dv/fcm_far_model.sv
// Far-side model: configuration flash and the FPGA configuration port.
// Assumes the manager's flash read and FPGA byte strobes on one clock.
`timescale 1ns/100ps
`default_nettype none
module fcm_far_model #(
    parameter int N_BYTES = 4
) (
    // Clock and pacing
    input  wire logic       clk_in,
    input  wire logic       slow_in,
    input  wire logic       jtag_active_in,
    // Flash side
    input  wire logic       rd_start_in,
    input  wire logic [1:0] image_in,
    output logic            byte_valid_out = 1'b0,
    output logic [7:0]      byte_out = 8'h00,
    output logic            last_out = 1'b0,
    // FPGA side
    input  wire logic       prog_in,
    input  wire logic       cfg_valid_in,
    input  wire logic [7:0] cfg_byte_in,
    output logic            done_out = 1'b0,
    output logic [7:0]      got_byte_out = 8'h00
);
    int         sent   = N_BYTES;
    int         got    = 0;
    logic       gap    = 1'b0;
    logic       jtag_q = 1'b0;
    logic [1:0] img_q  = 2'h0;
    // ---------------------------------------------------------------
    // Flash read: contents depend on the image; idle data is inverted
    // ---------------------------------------------------------------
    // four distinct images
    always @(posedge clk_in) begin
        gap <= slow_in & ~gap;
        if (rd_start_in) begin
            sent <= 0;
            img_q <= image_in;
        end else if (sent < N_BYTES && !gap) begin
            byte_valid_out <= 1'b1;
            byte_out <= {img_q, 3'b101, 3'(sent)};
            last_out <= (sent == N_BYTES - 1);
            sent <= sent + 1;
        end else begin
            byte_valid_out <= 1'b0;
            last_out <= 1'b0;
            byte_out <= ~byte_out;
        end
    end
    // ---------------------------------------------------------------
    // FPGA: done after a full image or at the end of a JTAG load
    // ---------------------------------------------------------------
    // external JTAG load
    always @(posedge clk_in) begin
        jtag_q <= jtag_active_in;
        if (prog_in || (jtag_active_in && !jtag_q)) begin
            got <= 0;
            done_out <= 1'b0;
        end else if (jtag_q && !jtag_active_in) begin
            done_out <= 1'b1;
        end else if (cfg_valid_in) begin
            got_byte_out <= cfg_byte_in;
            got <= got + 1;
            done_out <= (got + 1 >= N_BYTES);
        end
    end
endmodule // fcm_far_model
`default_nettype wire

// File: dv/fpga_config_manager_tb_top.sv
// Testbench for the configuration manager: boot, reloads, PCIe hold-over.
// Assumes the far-side model for flash and FPGA; no random stimulus.
`timescale 1ns/100ps
`default_nettype none
module fpga_config_manager_tb_top;
    import fcm_pkg::*;
    localparam logic [31:0] ID = {DEVICE_ID, VENDOR_ID};
    logic         clk_in = 1'b0;
    logic         srst_in = 1'b1;
    logic         jtag_act = 1'b0;
    logic         slow = 1'b0;
    logic         wr_req = 1'b0;
    logic [1:0]   sw = 2'h3;
    fcm_cfg_req_s req = '0;
    fcm_cfg_rsp_s rsp;
    fcm_cmd_s     cmd = '0;
    logic         prog, cvalid, drive_n, rd_start, grant, traffic, fdone, bvalid, blast;
    logic [7:0]   cbyte, fbyte, got;
    logic [1:0]   img;
    logic [2:0]   state;
    int           n_fail = 0;
    int           compares = 0;
    int           cyc = 0;
    // Clock and timeout
    always #50 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            results();
        end
    end
    fcm_config_manager i_dut (.clk_in(clk_in), .srst_in(srst_in), .boot_switch_in(sw),
        .jtag_active_in(jtag_act), .cfg_req_in(req), .cfg_rsp_out(rsp), .cmd_in(cmd),
        .flash_wr_req_in(wr_req), .fpga_prog_out(prog), .fpga_cfg_valid_out(cvalid),
        .fpga_cfg_byte_out(cbyte), .fpga_done_in(fdone), .cfg_drive_n_out(drive_n),
        .flash_rd_start_out(rd_start), .flash_image_out(img), .flash_wr_grant_out(grant),
        .flash_byte_valid_in(bvalid), .flash_byte_in(fbyte), .flash_last_in(blast),
        .traffic_enable_out(traffic), .state_out(state));
    fcm_far_model i_far (.clk_in(clk_in), .slow_in(slow), .jtag_active_in(jtag_act),
        .rd_start_in(rd_start), .image_in(img), .byte_valid_out(bvalid), .byte_out(fbyte),
        .last_out(blast), .prog_in(prog), .cfg_valid_in(cvalid), .cfg_byte_in(cbyte),
        .done_out(fdone), .got_byte_out(got));
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_state(input logic [2:0] st, input int lim);
        for (int i = 0; i < lim && state !== st; i++) begin
            @(posedge clk_in);
            #1;
        end
        check("state", state, st);
    endtask
    // One config access; reads are compared one cycle after the request
    task automatic cfg(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [31:0] exp);
        @(posedge clk_in);
        req <= '{1'b1, wr, a, d};
        @(posedge clk_in);
        req <= '0;
        #1;
        if (!wr) begin
            check("rsp_valid", rsp.valid, 1'b1);
            check("rsp_data", rsp.data, exp);
        end
    endtask
    task automatic results;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_boot;
        wait_state(FCM_LOAD_FLASH, 4);
        check("prog", prog, 1'b1);
        check("rd_start", rd_start, 1'b1);
        check("image", img, 2'h3);
        check("traffic", traffic, 1'b0);
        cfg(1'b0, 4'h0, 32'h0, ID);
        wait_state(FCM_RUN, 40);
        check("traffic", traffic, 1'b1);
        check("fpga_byte", got, 8'heb);
    endtask
    task automatic t_reload;
        @(posedge clk_in);
        cmd.image <= 2'h2;
        slow <= 1'b1;
        @(posedge clk_in);
        cmd.reload <= 1'b1;
        @(posedge clk_in);
        cmd.reload <= 1'b0;
        wr_req <= 1'b1;
        #1;
        check("state", state, FCM_LOAD_FLASH);
        check("image", img, 2'h2);
        check("traffic", traffic, 1'b0);
        cfg(1'b1, 4'h1, 32'h5a5a_0f0f, 32'h0);
        cfg(1'b1, 4'h0, 32'hffffffff, 32'h0);
        cfg(1'b0, 4'h0, 32'h0, ID);
        check("grant", grant, 1'b0);
        wait_state(FCM_RUN, 60);
        check("grant", grant, 1'b0);
        check("fpga_byte", got, 8'hab);
        cfg(1'b0, 4'h0, 32'h0, ID);
        cfg(1'b0, 4'h1, 32'h0, 32'h5a5a_0f0f);
    endtask
    task automatic t_stream;
        @(posedge clk_in);
        slow <= 1'b0;
        wr_req <= 1'b0;
        cmd.stream_start <= 1'b1;
        @(posedge clk_in);
        cmd.stream_start <= 1'b0;
        #1;
        check("state", state, FCM_LOAD_HOST);
        check("drive_n", drive_n, 1'b0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in);
            cmd.stream_valid <= 1'b1;
            cmd.stream_byte <= {6'h30, 2'(i)};
            cmd.stream_last <= (i == 3);
            @(posedge clk_in);
            cmd.stream_valid <= 1'b0;
            cmd.stream_last <= 1'b0;
            #1;
            check("cfg_valid", cvalid, 1'b1);
            check("cfg_byte", cbyte, {6'h30, 2'(i)});
        end
        wait_state(FCM_RUN, 20);
        check("grant", grant, 1'b0);
        check("fpga_byte", got, 8'hc3);
    endtask
    task automatic t_jtag;
        @(posedge clk_in);
        jtag_act <= 1'b1;
        wait_state(FCM_LOAD_JTAG, 4);
        check("drive_n", drive_n, 1'b1);
        check("prog", prog, 1'b0);
        check("traffic", traffic, 1'b0);
        cfg(1'b0, 4'h0, 32'h0, ID);
        @(posedge clk_in);
        jtag_act <= 1'b0;
        wait_state(FCM_RUN, 6);
        cfg(1'b0, 4'h0, 32'h0, ID);
        cfg(1'b0, 4'h1, 32'h0, 32'h5a5a_0f0f);
    endtask
    task automatic t_flash_wr;
        @(posedge clk_in);
        wr_req <= 1'b1;
        @(posedge clk_in);
        #1;
        check("grant", grant, 1'b1);
        @(posedge clk_in);
        wr_req <= 1'b0;
        @(posedge clk_in);
        #1;
        check("grant", grant, 1'b0);
    endtask
    // Mid-run reset with a new switch setting: boot must follow the switch
    task automatic t_reboot;
        @(posedge clk_in);
        srst_in <= 1'b1;
        sw <= 2'h1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        #1;
        check("drive_n", drive_n, 1'b1);
        check("traffic", traffic, 1'b0);
        wait_state(FCM_LOAD_FLASH, 4);
        check("image", img, 2'h1);
        check("prog", prog, 1'b1);
        cfg(1'b0, 4'h0, 32'h0, ID);
        wait_state(FCM_RUN, 40);
        check("fpga_byte", got, 8'h6b);
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_in);
        srst_in <= 1'b0;
        t_boot();
        t_reload();
        t_stream();
        t_jtag();
        t_flash_wr();
        t_reboot();
        results();
    end
endmodule // fpga_config_manager_tb_top
`default_nettype wire
